// ### src/clk_route_cfg.sv
// Purpose: clock source routing, prescaler and loop control with staged registers
// Assumes: source edges arrive as one-cycle enables on mclk (osc_tick, ext_tick)
// Notes: classic wishbone slave, one wait state, unmapped reads return zero
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module clk_route_cfg #(
  parameter int CAL_LEN = clk_route_pkg::CAL_CYCLES // calibration length, cycles
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic osc_tick,
  input wire logic ext_tick,
  output logic dist_tick,
  output logic pll_power_down,
  output logic osc_power_en,
  output logic fb_from_ext,
  output logic pfd_polarity_neg,
  output logic [2:0] ref_input_en,
  output logic cal_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  clk_route_pkg::cfg_t stage_r; // software-written copy
  clk_route_pkg::cfg_t act_r; // copy that steers hardware
  clk_route_pkg::cfg_t nvm_cfg_r; // retained image, no reset
  logic [7:0] nvm_tag_r; // marks a valid image, no reset
  clk_route_pkg::seq_t seq_r; // control sequencer
  logic [15:0] cal_cnt_r; // calibration cycle count
  logic cal_done_r; // last calibration finished
  logic [2:0] div_cnt_r; // prescaler phase
  logic dist_tick_r; // registered distribution enable
  logic ack_r; // bus acknowledge
  logic [31:0] rd_r; // registered read data
  logic [clk_route_pkg::IDX_W-1:0] idx; // word index
  logic wr; // write taken at this edge
  logic upd; // commit strobe
  logic nvm_save; // save request
  logic restore; // load from storage now
  logic cal_start; // calibration trigger
  logic src_tick; // selected source edge
  logic [2:0] ratio; // active division ratio

  // ratio code to division: 000 is two, 111 clamps to six
  function automatic logic [2:0] ratio_of(input logic [2:0] code);
    logic [2:0] r;
    r = code;
    if (code == 3'h0) begin
      r = 3'h2;
    end else if (code == 3'h7) begin
      r = 3'h6;
    end
    return r;
  endfunction : ratio_of

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // write lands on the edge where the master sees ack
  assign idx = wb_adr_i[11:2];
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
  assign upd = wr && idx == clk_route_pkg::IDX_UPD
    && wb_dat_i[clk_route_pkg::UPD_BIT];
  assign nvm_save = wr && idx == clk_route_pkg::IDX_NVM
    && wb_dat_i[clk_route_pkg::NVM_SAVE_BIT];
  // restore only when the retained tag is intact
  // first power-up leaves the tag unknown, which reads as no image
  assign restore = (seq_r == clk_route_pkg::ST_BOOT || (wr
    && idx == clk_route_pkg::IDX_NVM && wb_dat_i[clk_route_pkg::NVM_LOAD_BIT]))
    && nvm_tag_r == clk_route_pkg::NVM_MAGIC;
  // only a 0 -> 1 change of the committed bit starts a run
  // a start that lands during a run is not queued; wait for done first
  assign cal_start = upd && stage_r.cal && !act_r.cal;

  // one wait state, ack drops the cycle after it rose
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end
  assign wb_ack_o = ack_r;

  // read data captured as ack rises; update strobe reads zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_r <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      rd_r <= 32'h0000_0000;
      unique case (idx)
        clk_route_pkg::IDX_PLL: begin
          rd_r[clk_route_pkg::PLL_MODE_LSB +: 2] <= stage_r.pll_mode;
          rd_r[clk_route_pkg::PFD_POL_BIT] <= stage_r.pfd_neg;
        end
        clk_route_pkg::IDX_CAL: rd_r[clk_route_pkg::CAL_BIT] <= stage_r.cal;
        clk_route_pkg::IDX_REF: rd_r[2:0] <= stage_r.ref_en;
        clk_route_pkg::IDX_DIV: rd_r[clk_route_pkg::DIV_LSB +: 3] <= stage_r.div_code;
        clk_route_pkg::IDX_SRC: begin
          rd_r[clk_route_pkg::SRC_BIT] <= stage_r.src_osc;
          rd_r[clk_route_pkg::BYP_BIT] <= stage_r.bypass;
        end
        clk_route_pkg::IDX_STAT: begin
          rd_r[4:0] <= {fb_from_ext, osc_power_en, pll_power_down, cal_done_r, cal_busy};
        end
        default: rd_r <= 32'h0000_0000; // unmapped or write-only
      endcase
    end
  end
  assign wb_dat_o = rd_r;

  ////////////////////////////////////////////////////////////////////////////
  // configuration storage

  // staged copy: software writes land here first
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage_r <= clk_route_pkg::CFG_RESET;
    end else if (restore) begin
      stage_r <= nvm_cfg_r;
    end else if (wr) begin
      unique case (idx)
        clk_route_pkg::IDX_PLL: begin
          stage_r.pll_mode <= wb_dat_i[clk_route_pkg::PLL_MODE_LSB +: 2];
          stage_r.pfd_neg <= wb_dat_i[clk_route_pkg::PFD_POL_BIT];
        end
        clk_route_pkg::IDX_CAL: stage_r.cal <= wb_dat_i[clk_route_pkg::CAL_BIT];
        clk_route_pkg::IDX_REF: stage_r.ref_en <= wb_dat_i[2:0];
        clk_route_pkg::IDX_DIV: stage_r.div_code <= wb_dat_i[clk_route_pkg::DIV_LSB +: 3];
        clk_route_pkg::IDX_SRC: begin
          stage_r.src_osc <= wb_dat_i[clk_route_pkg::SRC_BIT];
          stage_r.bypass <= wb_dat_i[clk_route_pkg::BYP_BIT];
        end
        default: stage_r <= stage_r; // other words do not touch config
      endcase
    end
  end

  // active copy: changes only on commit or restore
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      act_r <= clk_route_pkg::CFG_RESET;
    end else if (restore) begin
      act_r <= nvm_cfg_r;
    end else if (upd) begin
      act_r <= stage_r;
    end
  end

  // retained image survives reset on purpose, so no reset branch
  always_ff @(posedge mclk) begin
    if (nvm_save) begin
      nvm_cfg_r <= act_r;
      nvm_tag_r <= clk_route_pkg::NVM_MAGIC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and calibration

  // boot does one restore attempt, then runs; cal counts a fixed length
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_r <= clk_route_pkg::ST_BOOT;
      cal_cnt_r <= 16'h0000;
    end else begin
      unique case (seq_r)
        clk_route_pkg::ST_BOOT: seq_r <= clk_route_pkg::ST_RUN;
        clk_route_pkg::ST_RUN: begin
          cal_cnt_r <= 16'h0000;
          if (cal_start) begin
            seq_r <= clk_route_pkg::ST_CAL;
          end
        end
        clk_route_pkg::ST_CAL: begin
          cal_cnt_r <= cal_cnt_r + 16'h0001;
          if (cal_cnt_r == 16'(CAL_LEN - 1)) begin
            seq_r <= clk_route_pkg::ST_RUN;
          end
        end
        default: seq_r <= clk_route_pkg::ST_RUN; // illegal code 10
      endcase
    end
  end
  assign cal_busy = seq_r == clk_route_pkg::ST_CAL;

  // done flag: set on finish wins over clear on a new start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cal_done_r <= 1'b0;
    end else if (cal_busy && cal_cnt_r == 16'(CAL_LEN - 1)) begin
      cal_done_r <= 1'b1;
    end else if (cal_start) begin
      cal_done_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing and prescaler

  // oscillator edges are ignored while the external input is chosen
  assign src_tick = act_r.src_osc ? osc_tick : ext_tick;
  assign ratio = ratio_of(act_r.div_code);

  // prescaler phase counter, advances on source edges only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= 3'h0;
    end else if (upd || restore) begin
      div_cnt_r <= 3'h0; // restart phase on a new ratio
    end else if (src_tick) begin
      div_cnt_r <= (div_cnt_r >= ratio - 3'h1) ? 3'h0 : div_cnt_r + 3'h1;
    end
  end

  // registered output: one enable per source edge or per ratio edges
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dist_tick_r <= 1'b0;
    end else if (act_r.bypass) begin
      dist_tick_r <= src_tick;
    end else begin
      dist_tick_r <= src_tick && div_cnt_r >= ratio - 3'h1;
    end
  end
  assign dist_tick = dist_tick_r;

  // loop controls decoded from the active copy only
  assign pll_power_down = act_r.pll_mode == clk_route_pkg::PLL_ASYNC_PD;
  assign osc_power_en = act_r.src_osc;
  assign fb_from_ext = act_r.pll_mode == clk_route_pkg::PLL_NORMAL
    && !act_r.src_osc;
  assign pfd_polarity_neg = act_r.pfd_neg;
  assign ref_input_en = act_r.ref_en;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_commit_copy: assert property (upd && !restore |=> act_r == $past(stage_r))
    else $error("commit did not copy staged config");
  a_active_hold: assert property (!upd && !restore |=> $stable(act_r))
    else $error("active config changed without commit");
  a_pll_off: assert property (upd && !restore
    && stage_r.pll_mode == clk_route_pkg::PLL_ASYNC_PD |=> pll_power_down)
    else $error("loop not powered down after mode 01");
  a_osc_unused: assert property (upd && !restore && !stage_r.src_osc
    |=> !osc_power_en)
    else $error("oscillator powered with external source");
  a_osc_gated: assert property (!act_r.src_osc && osc_tick && !ext_tick |=> !dist_tick)
    else $error("oscillator edge reached distribution");
  a_fb_external: assert property (upd && !restore && !stage_r.src_osc
    && stage_r.pll_mode == clk_route_pkg::PLL_NORMAL |=> fb_from_ext)
    else $error("external source not fed to feedback");
  a_cal_run: assert property (cal_start |=> cal_busy [*8])
    else $error("calibration did not run");
  a_cal_rearm: assert property (upd && act_r.cal && !cal_busy |=> !cal_busy)
    else $error("calibration restarted without clearing the bit");
  a_bypass_pass: assert property (act_r.bypass && src_tick |=> dist_tick)
    else $error("bypass dropped a source edge");
  a_no_edge: assert property (!$past(src_tick) |-> !dist_tick)
    else $error("distribution edge without source edge");
  a_boot_dflt: assert property (seq_r == clk_route_pkg::ST_BOOT
    |-> restore || act_r == clk_route_pkg::CFG_RESET)
    else $error("boot config not at defaults");

  c_cal: cover property (cal_start ##1 cal_busy);
  c_commit: cover property (upd ##1 !pll_power_down);
  c_divided: cover property (!act_r.bypass && ratio == 3'h6 && dist_tick);
  c_restore: cover property (restore);
  c_bypass: cover property (act_r.bypass && dist_tick);

endmodule : clk_route_cfg

// ### src/clk_route_pkg.sv
// Purpose: shared constants and types for the clock source routing block
// Assumes: registers sit at word index = printed offset, byte address = 4 * index
// Notes: config travels as one packed struct, staged and active copies
package clk_route_pkg;
  // word index width on the bus (byte address bits 11:2)
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_PLL = 10'h010; // pll mode, detector polarity
  localparam logic [IDX_W-1:0] IDX_CAL = 10'h018; // calibration bit
  localparam logic [IDX_W-1:0] IDX_REF = 10'h01C; // reference input enables
  localparam logic [IDX_W-1:0] IDX_DIV = 10'h1E0; // prescaler ratio code
  localparam logic [IDX_W-1:0] IDX_SRC = 10'h1E1; // source select, bypass
  localparam logic [IDX_W-1:0] IDX_UPD = 10'h232; // update strobe
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h240; // block status
  localparam logic [IDX_W-1:0] IDX_NVM = 10'h241; // storage save / restore
  // field positions
  localparam int PLL_MODE_LSB = 0;
  localparam int PFD_POL_BIT = 7;
  localparam int CAL_BIT = 0;
  localparam int DIV_LSB = 0;
  localparam int SRC_BIT = 1;
  localparam int BYP_BIT = 0;
  localparam int UPD_BIT = 0;
  localparam int NVM_SAVE_BIT = 0;
  localparam int NVM_LOAD_BIT = 1;
  // field codes and reset values
  localparam logic [1:0] PLL_NORMAL = 2'h0;
  localparam logic [1:0] PLL_ASYNC_PD = 2'h1;
  localparam logic [2:0] DIV_CODE_RST = 3'h0;
  localparam logic [7:0] NVM_MAGIC = 8'hA5;
  // timing count of one calibration run
  localparam int CAL_CYCLES = 256;
  // one configuration image
  typedef struct packed {
    logic [1:0] pll_mode; // loop power mode
    logic pfd_neg; // detector polarity, 1 = negative
    logic cal; // calibration request bit
    logic [2:0] ref_en; // reference input enables
    logic [2:0] div_code; // prescaler ratio code
    logic src_osc; // 1 = internal oscillator
    logic bypass; // 1 = skip the prescaler
  } cfg_t;
  localparam cfg_t CFG_RESET = '{pll_mode: PLL_ASYNC_PD, pfd_neg: 1'b0, cal: 1'b0,
    ref_en: 3'h0, div_code: DIV_CODE_RST, src_osc: 1'b0, bypass: 1'b0};
  // control sequencer, gray along boot -> run -> cal -> run
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN = 2'b01,
    ST_CAL = 2'b11
  } seq_t;
endpackage : clk_route_pkg

// ### test/clk_src_model.sv
// Purpose: far-side clock sources, external input and internal oscillator
// Assumes: each source edge is a one-cycle enable on mclk
// Notes: a source is silent while its run input is low, phase restarts on run
`timescale 1ns/100ps
module clk_src_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ext_run,
  input wire logic osc_run,
  output logic ext_tick,
  output logic osc_tick
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] ext_ph_r; // external edge phase, one edge in three cycles
  logic [1:0] osc_ph_r; // oscillator edge phase
  // external source, kept slow so bypass stays legal
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_ph_r <= 2'h0;
      ext_tick <= 1'b0;
    end else if (!ext_run) begin
      ext_ph_r <= 2'h0;
      ext_tick <= 1'b0;
    end else begin
      ext_ph_r <= (ext_ph_r == 2'h2) ? 2'h0 : ext_ph_r + 2'h1;
      ext_tick <= (ext_ph_r == 2'h2);
    end
  end
  // oscillator, same rate so counts compare directly
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_ph_r <= 2'h0;
      osc_tick <= 1'b0;
    end else if (!osc_run) begin
      osc_ph_r <= 2'h0;
      osc_tick <= 1'b0;
    end else begin
      osc_ph_r <= (osc_ph_r == 2'h2) ? 2'h0 : osc_ph_r + 2'h1;
      osc_tick <= (osc_ph_r == 2'h2);
    end
  end
endmodule : clk_src_model

// ### test/tb_clock_source_routing_config.sv
// Purpose: self-checking bench for the clock routing block
// Assumes: classic wishbone, one register word per access
// Notes: short calibration run; sixty source edges per divider window
`timescale 1ns/100ps
module tb_clock_source_routing_config;
  localparam int CAL_N = 12; // shortened calibration run
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat_w = 32'h00000000;
  logic [31:0] dat_r;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [3:0] sel = 4'hF; // byte lanes, low lane gates writes
  logic ext_run = 1'b0;
  logic osc_run = 1'b0;
  logic ack, osc_tick, ext_tick, dist_tick, pll_pd, osc_en, fb_ext, pol_neg, busy;
  logic [2:0] ref_en;
  logic [31:0] rd; // data of the last bus cycle
  int n_fail = 0;
  int n_checks = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  clk_route_cfg #(.CAL_LEN(CAL_N)) dut (.mclk(mclk), .rst(rst), .wb_adr_i(adr),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .osc_tick(osc_tick), .ext_tick(ext_tick),
    .dist_tick(dist_tick), .pll_power_down(pll_pd), .osc_power_en(osc_en),
    .fb_from_ext(fb_ext), .pfd_polarity_neg(pol_neg), .ref_input_en(ref_en),
    .cal_busy(busy));
  clk_src_model src (.mclk(mclk), .rst(rst), .ext_run(ext_run), .osc_run(osc_run),
    .ext_tick(ext_tick), .osc_tick(osc_tick));
  // free-running bus clock
  initial begin
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic [clk_route_pkg::IDX_W-1:0] idx, input logic w,
                    input logic [31:0] d);
    int k;
    @(posedge mclk);
    adr <= {idx, 2'b00};
    we <= w;
    dat_w <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (ack === 1'b1) break;
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k == 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wb
  // commit and let the active copy settle
  task automatic commit();
    wb(clk_route_pkg::IDX_UPD, 1'b1, 32'h00000001);
    repeat (2) @(posedge mclk);
  endtask : commit
  // sixty edges from one source, count what reaches distribution
  task automatic run_src(input logic use_osc, output int cnt);
    cnt = 0;
    @(posedge mclk);
    if (use_osc) osc_run <= 1'b1;
    else ext_run <= 1'b1;
    repeat (180) begin
      @(posedge mclk);
      if (dist_tick === 1'b1) cnt++;
    end
    osc_run <= 1'b0;
    ext_run <= 1'b0;
    repeat (6) begin
      @(posedge mclk);
      if (dist_tick === 1'b1) cnt++;
    end
  endtask : run_src
  // commit, then count calibration busy cycles
  task automatic cal_run(output int cnt);
    wb(clk_route_pkg::IDX_UPD, 1'b1, 32'h00000001);
    cnt = 0;
    repeat (40) begin
      @(posedge mclk);
      if (busy === 1'b1) cnt++;
    end
  endtask : cal_run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    check("pd", {31'h0, pll_pd}, 32'h1);
    check("osc", {31'h0, osc_en}, 32'h0);
    check("ref", {29'h0, ref_en}, 32'h0);
    wb(clk_route_pkg::IDX_PLL, 1'b0, 32'h0);
    check("mode", rd, 32'h1);
    wb(clk_route_pkg::IDX_SRC, 1'b0, 32'h0);
    check("src", rd, 32'h0);
    wb(10'h3FF, 1'b0, 32'h0);
    check("unmapped", rd, 32'h0);
    run_src(1'b0, n);
    check("div2", n, 32'd30);
  endtask : t_defaults
  // staged writes, loop mode, polarity, feedback path
  task automatic t_stage();
    wb(clk_route_pkg::IDX_PLL, 1'b1, 32'h80);
    wb(clk_route_pkg::IDX_REF, 1'b1, 32'h5);
    repeat (2) @(posedge mclk);
    check("staged pd", {31'h0, pll_pd}, 32'h1);
    commit();
    check("pd on", {31'h0, pll_pd}, 32'h0);
    check("fb", {31'h0, fb_ext}, 32'h1);
    check("pol", {31'h0, pol_neg}, 32'h1);
    check("ref on", {29'h0, ref_en}, 32'h5);
    wb(clk_route_pkg::IDX_UPD, 1'b0, 32'h0);
    check("strobe", rd, 32'h0);
    sel <= 4'h0;
    wb(clk_route_pkg::IDX_PLL, 1'b1, 32'h03);
    sel <= 4'hF;
    wb(clk_route_pkg::IDX_PLL, 1'b0, 32'h0);
    check("sel0 ignored", rd, 32'h80);
    wb(clk_route_pkg::IDX_PLL, 1'b1, 32'h01);
    commit();
    check("pd off", {31'h0, pll_pd}, 32'h1);
    check("fb off", {31'h0, fb_ext}, 32'h0);
    check("pol pos", {31'h0, pol_neg}, 32'h0);
  endtask : t_stage
  // every ratio code, then bypass and source select
  task automatic t_div();
    int exp;
    for (int c = 0; c < 8; c++) begin
      wb(clk_route_pkg::IDX_DIV, 1'b1, c);
      commit();
      exp = (c == 0) ? 30 : 60 / ((c == 7) ? 6 : c);
      run_src(1'b0, n);
      check("ratio", n, exp);
    end
    wb(clk_route_pkg::IDX_SRC, 1'b1, 32'h1);
    commit();
    run_src(1'b0, n);
    check("bypass", n, 32'd60);
    run_src(1'b1, n);
    check("osc unused", n, 32'd0);
    wb(clk_route_pkg::IDX_SRC, 1'b1, 32'h2);
    commit();
    check("osc on", {31'h0, osc_en}, 32'h1);
    run_src(1'b1, n);
    check("osc div6", n, 32'd10);
    run_src(1'b0, n);
    check("ext unused", n, 32'd0);
  endtask : t_div
  // calibration start, no restart, clear and restart
  task automatic t_cal();
    wb(clk_route_pkg::IDX_CAL, 1'b1, 32'h1);
    cal_run(n);
    check("cal len", n, CAL_N);
    wb(clk_route_pkg::IDX_STAT, 1'b0, 32'h0);
    check("cal done", {31'h0, rd[1]}, 32'h1);
    cal_run(n);
    check("no restart", n, 32'd0);
    wb(clk_route_pkg::IDX_CAL, 1'b1, 32'h0);
    cal_run(n);
    check("cleared", n, 32'd0);
    wb(clk_route_pkg::IDX_CAL, 1'b1, 32'h1);
    cal_run(n);
    check("recal", n, CAL_N);
  endtask : t_cal
  // save, disturb, restore by command and by reset
  task automatic t_nvm();
    wb(clk_route_pkg::IDX_NVM, 1'b1, 32'h1);
    wb(clk_route_pkg::IDX_SRC, 1'b1, 32'h0);
    commit();
    wb(clk_route_pkg::IDX_NVM, 1'b1, 32'h2);
    repeat (2) @(posedge mclk);
    check("restored", {31'h0, osc_en}, 32'h1);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check("boot osc", {31'h0, osc_en}, 32'h1);
    wb(clk_route_pkg::IDX_DIV, 1'b0, 32'h0);
    check("boot div", rd, 32'h7);
  endtask : t_nvm
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_defaults();
    t_stage();
    t_div();
    t_cal();
    t_nvm();
    tally_and_finish();
  end
endmodule : tb_clock_source_routing_config
